// ---- logic/urx_core.sv ----
// Receive path with three-deep FIFO, error reporting, flow control and loop routing
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "urx_regs.svh"
module urx_core
    import urx_pkg::*;
#(
    parameter int DEPTH = `URX_FIFO_DEPTH
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output      logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output      logic        s_axi_wready,
    output      logic [1:0]  s_axi_bresp,
    output      logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output      logic        s_axi_arready,
    output      logic [31:0] s_axi_rdata,
    output      logic [1:0]  s_axi_rresp,
    output      logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        serial_in,
    output      logic        serial_out,
    input  wire logic        tx_line,
    input  wire logic        tx_empty_in,
    input  wire logic        tx_room_in,
    output      logic        tx_empty_flag,
    output      logic        tx_room_flag,
    output      logic        tx_wr_block,
    output      logic        req_to_send_n,
    output      logic        rx_ready_pin_n
);

    // Serial input synchroniser, first stage read only by the second
    logic sin_meta_ff;
    logic sin_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sin_meta_ff <= 1'b1;
            sin_ff      <= 1'b1;
        end else begin
            sin_meta_ff <= serial_in;
            sin_ff      <= sin_meta_ff;
        end
    end

    // Control registers
    logic [6:0]  mode_reg_first_ff;
    logic [15:0] baud_ff;
    logic        rx_en_ff;

    wire       err_blk   = mode_reg_first_ff[`URX_MODE_ERR_BLK];
    wire       irq_full  = mode_reg_first_ff[`URX_MODE_IRQ_FULL];
    wire       rts_ctl   = mode_reg_first_ff[`URX_MODE_RTS_CTL];
    wire       par_en    = mode_reg_first_ff[`URX_MODE_PAR_EN];
    wire       par_odd   = mode_reg_first_ff[`URX_MODE_PAR_ODD];
    wire urx_chan_t chan = urx_chan_t'(mode_reg_first_ff[`URX_MODE_CHAN_LO +: 2]);

    // Routing is wiring off the mode bits, so a change acts at once; serial_out follows one flop later [RULE17] [RULE23]
    wire is_echo   = (chan == CHAN_ECHO);
    wire is_local  = (chan == CHAN_LOCAL);
    wire is_remote = (chan == CHAN_REMOTE);
    wire rx_line   = is_local ? tx_line : sin_ff;                        // [RULE20]
    wire nxt_sout  = is_local ? 1'b1 : ((is_echo || is_remote) ? sin_ff : tx_line); // [RULE18] [RULE20] [RULE21]

    logic sout_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) sout_ff <= 1'b1;
        else          sout_ff <= nxt_sout;
    end
    assign serial_out    = sout_ff;
    // Transmitter is cut off from the host while it echoes [RULE18] [RULE21]
    assign tx_wr_block   = is_echo || is_remote;
    assign tx_empty_flag = tx_empty_in && !tx_wr_block;
    assign tx_room_flag  = tx_room_in && !tx_wr_block;

    // AXI4-Lite write side
    logic        aw_got_ff;
    logic        w_got_ff;
    logic [7:0]  awaddr_ff;
    logic [31:0] wdata_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        wstrb0_ff;

    assign s_axi_awready = !aw_got_ff && !bvalid_ff;
    assign s_axi_wready  = !w_got_ff && !bvalid_ff;
    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs  = s_axi_wvalid && s_axi_wready;
    wire aw_ok = aw_got_ff || aw_hs;
    wire w_ok  = w_got_ff || w_hs;
    wire wr_go = aw_ok && w_ok && !bvalid_ff;
    wire [7:0]  wr_addr = aw_got_ff ? awaddr_ff : s_axi_awaddr;
    wire [31:0] wr_data = w_got_ff ? wdata_ff : s_axi_wdata;
    wire        wr_lane0 = w_got_ff ? wstrb0_ff : s_axi_wstrb[0];
    wire wr_mode = wr_go && wr_lane0 && (wr_addr == `URX_OFF_MODE);
    wire wr_cmd  = wr_go && wr_lane0 && (wr_addr == `URX_OFF_CMD);
    wire wr_baud = wr_go && (wr_addr == `URX_OFF_BAUD);
    wire wr_map  = (wr_addr == `URX_OFF_MODE) || (wr_addr == `URX_OFF_CMD) ||
                   (wr_addr == `URX_OFF_STATUS) || (wr_addr == `URX_OFF_RXBUF) ||
                   (wr_addr == `URX_OFF_IRQ) || (wr_addr == `URX_OFF_BAUD);

    // A strobe-less data word is held, so wstrb lane 0 is latched as a qualified copy
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff  <= 32'h0000_0000;
            wstrb0_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff  <= `URX_RESP_OKAY;
        end else begin
            if (aw_hs && !wr_go) aw_got_ff <= 1'b1;
            else if (wr_go)      aw_got_ff <= 1'b0;
            if (w_hs && !wr_go)  w_got_ff <= 1'b1;
            else if (wr_go)      w_got_ff <= 1'b0;
            if (aw_hs) awaddr_ff <= s_axi_awaddr;
            if (w_hs) begin
                wdata_ff  <= s_axi_wdata & {{24{1'b0}}, {8{s_axi_wstrb[0]}}} |
                             s_axi_wdata & {{16{1'b0}}, {8{s_axi_wstrb[1]}}, 8'h00};
                wstrb0_ff <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= wr_map ? `URX_RESP_OKAY : `URX_RESP_DECERR;
            end else if (s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp  = bresp_ff;

    wire cmd_rx_en  = wr_cmd && wr_data[`URX_CMD_RX_EN];
    wire cmd_rx_dis = wr_cmd && wr_data[`URX_CMD_RX_DIS];
    wire cmd_rx_rst = wr_cmd && wr_data[`URX_CMD_RX_RST];
    wire cmd_err_rst = wr_cmd && wr_data[`URX_CMD_ERR_RST];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg_first_ff <= `URX_MODE_RESET;
            baud_ff           <= `URX_BAUD_RESET;
            rx_en_ff          <= 1'b0;
        end else begin
            if (wr_mode) mode_reg_first_ff <= wr_data[6:0];
            if (wr_baud) baud_ff <= wr_data[15:0];
            // Reset beats enable in one write; receiver then stays off [RULE16]
            if (cmd_rx_rst || cmd_rx_dis) rx_en_ff <= 1'b0;
            else if (cmd_rx_en)           rx_en_ff <= 1'b1;
        end
    end

    // Oversampling tick, sixteen per bit time
    logic [15:0] div_ff;
    wire tick = (div_ff == 16'h0000);
    always_ff @(posedge aclk) begin
        if (!aresetn)  div_ff <= 16'h0000;
        else if (tick) div_ff <= baud_ff;
        else           div_ff <= div_ff - 16'h0001;
    end

    // FIFO of holding registers and the shift-register hold stage [RULE1] [RULE2]
    urx_entry_t fifo_ff [DEPTH];
    logic [1:0] count_ff;
    urx_entry_t hold_ff;
    logic       hold_vld_ff;

    wire fifo_full  = (count_ff == 2'(DEPTH));                           // [RULE5]
    wire fifo_avail = (count_ff != 2'h0);                                // [RULE3]

    // Receiver state machine
    urx_state_t st_ff;
    logic [4:0] smp_ff;
    logic [3:0] bit_ff;
    logic [7:0] shreg_ff;
    logic       parbit_ff;
    logic       ovr_ff;
    logic       rts_neg_ff;

    wire half_done = tick && (smp_ff == `URX_HALF_BIT - 5'h01);
    wire bit_done  = tick && (smp_ff == `URX_OVERSAMPLE - 5'h01);
    wire valid_start = (st_ff == RX_START) && half_done && !rx_line;
    wire last_data   = (bit_ff == `URX_DATA_BITS - 4'h1);
    wire char_done   = (st_ff == RX_STOP) && bit_done;
    wire par_calc    = ^shreg_ff ^ parbit_ff ^ par_odd;
    wire brk_seen    = (shreg_ff == 8'h00) && !parbit_ff && !rx_line;
    // Remote loop keeps the receiver off the FIFO and out of the error flags [RULE21]
    wire deliver     = char_done && !is_remote;
    // Start while full with a held character drops the held one [RULE13]
    wire overrun     = valid_start && fifo_full && hold_vld_ff && !is_remote;

    always_ff @(posedge aclk) begin
        if (!aresetn || cmd_rx_rst) begin
            st_ff     <= RX_IDLE;
            smp_ff    <= 5'h00;
            bit_ff    <= 4'h0;
            shreg_ff  <= 8'h00;
            parbit_ff <= 1'b0;
        end else begin
            if (tick) smp_ff <= smp_ff + 5'h01;
            unique case (st_ff)
                RX_IDLE: begin
                    smp_ff <= 5'h00;
                    if (rx_en_ff && !rx_line) st_ff <= RX_START;
                end
                RX_START: begin
                    if (half_done) begin
                        smp_ff    <= 5'h00;
                        bit_ff    <= 4'h0;
                        parbit_ff <= 1'b0;
                        st_ff     <= rx_line ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (bit_done) begin
                        shreg_ff <= {rx_line, shreg_ff[7:1]};
                        bit_ff   <= bit_ff + 4'h1;
                        smp_ff   <= 5'h00;
                        if (last_data) st_ff <= par_en && !is_remote ? RX_PAR : RX_STOP;
                    end
                end
                RX_PAR: begin
                    if (bit_done) begin
                        parbit_ff <= rx_line;
                        smp_ff    <= 5'h00;
                        st_ff     <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (bit_done) begin
                        smp_ff <= 5'h00;
                        st_ff  <= brk_seen ? RX_BRK : RX_IDLE;
                    end
                end
                RX_BRK: begin
                    // Line must go back to mark before the next start is hunted
                    if (rx_line) st_ff <= RX_IDLE;
                end
            endcase
        end
    end

    // Read side of the bus; only a receive-buffer read pops [RULE4] [RULE10]
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;
    assign s_axi_arready = !rvalid_ff;
    wire ar_hs  = s_axi_arvalid && s_axi_arready;
    wire rd_buf = ar_hs && (s_axi_araddr == `URX_OFF_RXBUF);
    wire pop    = rd_buf && fifo_avail;

    // New head arrives on a push into an empty FIFO or a pop that leaves entries
    wire push   = hold_vld_ff && (!fifo_full || pop);                    // [RULE12]
    wire [1:0] cnt_after_pop = pop ? count_ff - 2'h1 : count_ff;
    wire head_new = (pop && count_ff > 2'h1) || (push && cnt_after_pop == 2'h0);
    wire urx_entry_t head_in = (pop && count_ff > 2'h1) ? fifo_ff[1] : hold_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn || cmd_rx_rst) begin                                // [RULE16]
            count_ff    <= 2'h0;
            hold_vld_ff <= 1'b0;
            hold_ff     <= '0;
            for (int i = 0; i < DEPTH; i++) fifo_ff[i] <= '0;
        end else begin
            if (pop) begin
                for (int i = 0; i < DEPTH - 1; i++) fifo_ff[i] <= fifo_ff[i + 1];
            end
            if (push) fifo_ff[cnt_after_pop] <= hold_ff;
            count_ff <= cnt_after_pop + (push ? 2'h1 : 2'h0);
            if (deliver) begin
                hold_vld_ff <= 1'b1;
                hold_ff     <= '{data: shreg_ff, par_err: par_en && par_calc && !is_remote,
                                 frm_err: !rx_line, brk: brk_seen};      // [RULE2] [RULE19]
            end else if (push || overrun) begin
                hold_vld_ff <= 1'b0;                                     // [RULE13]
            end
        end
    end

    // Sticky block-mode flags and overrun; set wins over reset-error [RULE9]
    logic blk_par_ff;
    logic blk_frm_ff;
    logic blk_brk_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn || cmd_rx_rst) begin
            blk_par_ff <= 1'b0;
            blk_frm_ff <= 1'b0;
            blk_brk_ff <= 1'b0;
            ovr_ff     <= 1'b0;
        end else begin
            blk_par_ff <= (blk_par_ff && !cmd_err_rst) || (head_new && head_in.par_err);
            blk_frm_ff <= (blk_frm_ff && !cmd_err_rst) || (head_new && head_in.frm_err);
            blk_brk_ff <= (blk_brk_ff && !cmd_err_rst) || (head_new && head_in.brk);
            ovr_ff     <= (ovr_ff && !cmd_err_rst) || overrun;           // [RULE13]
        end
    end

    // Flow control: negate on valid start while full, reassert once a slot frees [RULE14]
    always_ff @(posedge aclk) begin
        if (!aresetn || cmd_rx_rst)           rts_neg_ff <= 1'b0;
        else if (!rts_ctl)                    rts_neg_ff <= 1'b0;
        else if (valid_start && fifo_full)    rts_neg_ff <= 1'b1;
        else if (!fifo_full)                  rts_neg_ff <= 1'b0;
    end
    assign req_to_send_n = rts_neg_ff;

    // Character mode shows head entry only; block mode the sticky OR [RULE7] [RULE8] [RULE9]
    wire head_ok  = fifo_avail;
    wire st_par   = err_blk ? blk_par_ff : (head_ok && fifo_ff[0].par_err);
    wire st_frm   = err_blk ? blk_frm_ff : (head_ok && fifo_ff[0].frm_err);
    wire st_brk   = err_blk ? blk_brk_ff : (head_ok && fifo_ff[0].brk);
    wire [7:0] chan_status_reg = {st_brk, st_frm, st_par, ovr_ff, tx_empty_flag,
                                  tx_room_flag, fifo_full, fifo_avail};
    // Interrupt source selects available or full [RULE6]
    wire rx_irq = irq_full ? fifo_full : fifo_avail;
    wire [7:0] irq_status_reg = {6'h00, rx_irq, 1'b0};
    // Ready pin tracks the interrupt bit through a flop [RULE22]
    logic rdy_n_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) rdy_n_ff <= 1'b1;
        else          rdy_n_ff <= !irq_status_reg[`URX_IRQ_RX_BIT];
    end
    assign rx_ready_pin_n = rdy_n_ff;

    // Buffer read stays allowed with the receiver disabled [RULE15]
    wire [31:0] rd_mux =
        (s_axi_araddr == `URX_OFF_MODE)   ? {25'h0, mode_reg_first_ff} :
        (s_axi_araddr == `URX_OFF_CMD)    ? {31'h0, rx_en_ff} :
        (s_axi_araddr == `URX_OFF_STATUS) ? {24'h0, chan_status_reg} :
        (s_axi_araddr == `URX_OFF_RXBUF)  ? {24'h0, fifo_avail ? fifo_ff[0].data : 8'h00} :
        (s_axi_araddr == `URX_OFF_IRQ)    ? {24'h0, irq_status_reg} :
        (s_axi_araddr == `URX_OFF_BAUD)   ? {16'h0, baud_ff} : 32'h0000_0000;
    wire rd_map = (s_axi_araddr == `URX_OFF_MODE) || (s_axi_araddr == `URX_OFF_CMD) ||
                  (s_axi_araddr == `URX_OFF_STATUS) || (s_axi_araddr == `URX_OFF_RXBUF) ||
                  (s_axi_araddr == `URX_OFF_IRQ) || (s_axi_araddr == `URX_OFF_BAUD);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= `URX_RESP_OKAY;
        end else if (ar_hs) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_mux;
            rresp_ff  <= rd_map ? `URX_RESP_OKAY : `URX_RESP_DECERR;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata  = rdata_ff;
    assign s_axi_rresp  = rresp_ff;

endmodule : urx_core

// ---- logic/urx_pkg.sv ----
// Types shared by the receive FIFO and loop block
package urx_pkg;

    typedef struct packed {
        logic [7:0] data;
        logic       par_err;
        logic       frm_err;
        logic       brk;
    } urx_entry_t;

    typedef enum logic [1:0] {
        CHAN_NORMAL = 2'h0,
        CHAN_ECHO   = 2'h1,
        CHAN_LOCAL  = 2'h2,
        CHAN_REMOTE = 2'h3
    } urx_chan_t;

    typedef enum logic [5:0] {
        RX_IDLE  = 6'h01,
        RX_START = 6'h02,
        RX_DATA  = 6'h04,
        RX_PAR   = 6'h08,
        RX_STOP  = 6'h10,
        RX_BRK   = 6'h20
    } urx_state_t;

endpackage : urx_pkg

// ---- logic/urx_regs.svh ----
// Register offsets, field positions and reset values of the receive FIFO and loop block
// Operation
// RULE1: Shift register feeds three-deep holding FIFO
// RULE2: Entries hold data, parity, framing, break
// RULE3: Character-available flag set while FIFO non-empty
// RULE4: Buffer read returns oldest entry, then pops
// RULE5: FIFO-full flag while three entries held
// RULE6: Option picks available or full as source
// RULE7: Mode bit picks character or block errors
// RULE8: Character mode shows head entry flags only
// RULE9: Block mode ORs head flags until reset-error
// RULE10: Status read never changes FIFO contents
// RULE11: Software reads status before receive buffer
// RULE12: Full FIFO keeps new character in shifter
// RULE13: Start while full and held sets overrun
// RULE14: Flow mode drops request-to-send when full; code drops it only on a valid start while the FIFO is full
// RULE15: FIFO stays readable after receiver disable
// RULE16: Receiver reset clears FIFO, flags, outputs
// RULE17: Loop mode change takes effect immediately
// RULE18: Echo retransmits received bits, blocks transmitter
// RULE19: Echo still checks and delivers characters
// RULE20: Local loop feeds transmitter into receiver
// RULE21: Remote loop echoes, delivers nothing, no errors
// RULE22: Ready pin is inverse of interrupt bit
// RULE23: Two-bit channel mode selects serial routing
`ifndef URX_REGS_SVH
`define URX_REGS_SVH

`define URX_OFF_MODE      8'h00
`define URX_OFF_CMD       8'h04
`define URX_OFF_STATUS    8'h08
`define URX_OFF_RXBUF     8'h0c
`define URX_OFF_IRQ       8'h10
`define URX_OFF_BAUD      8'h14

`define URX_MODE_ERR_BLK  0
`define URX_MODE_IRQ_FULL 1
`define URX_MODE_RTS_CTL  2
`define URX_MODE_CHAN_LO  3
`define URX_MODE_PAR_EN   5
`define URX_MODE_PAR_ODD  6

`define URX_CMD_RX_EN     0
`define URX_CMD_RX_DIS    1
`define URX_CMD_RX_RST    2
`define URX_CMD_ERR_RST   3

`define URX_IRQ_RX_BIT    1

`define URX_MODE_RESET    7'h00
`define URX_BAUD_RESET    16'h000c
`define URX_FIFO_DEPTH    3
`define URX_OVERSAMPLE    5'h10
`define URX_HALF_BIT      5'h08
`define URX_DATA_BITS     4'h8

`define URX_RESP_OKAY     2'h0
`define URX_RESP_DECERR   2'h3

`endif

// ---- verification/urx_core_props.sv ----
// Port-level checks for the receive FIFO and loop block
`timescale 1ns/1ps
module urx_core_props (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        serial_out,
    input wire logic        tx_empty_in,
    input wire logic        tx_room_in,
    input wire logic        tx_empty_flag,
    input wire logic        tx_room_flag,
    input wire logic        tx_wr_block,
    input wire logic        req_to_send_n,
    input wire logic        rx_ready_pin_n
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Checked straight through reset, so it carries its own empty disable
    a_reset_values: assert property (disable iff (1'b0)
        !aresetn |=> serial_out && !req_to_send_n && rx_ready_pin_n
            && !s_axi_bvalid && !s_axi_rvalid)
        else $error("bad reset values");
    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bresp dropped");
    a_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rdata dropped");
    a_ar_refused: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("read address ready wrong");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    a_tx_gated: assert property (
        tx_wr_block |-> !tx_empty_flag && !tx_room_flag)
        else $error("tx flags active while blocked");
    a_tx_passed: assert property (
        !tx_wr_block |-> tx_empty_flag == tx_empty_in && tx_room_flag == tx_room_in)
        else $error("tx flags not passed");
endmodule : urx_core_props

// ---- verification/urx_core_tb.sv ----
// Self-checking bench for the receive FIFO and loop block
`timescale 1ns/1ps
module urx_core_tb;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, loc;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, got;
    logic [1:0]  bresp, rresp, rsp;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        far_line, ser_in, tx_line, ser_out, wr_blk, txe, txr, rts_n, rdy_n;
    int          fail_count, samples_checked, low_cnt;

    urx_core dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .serial_in(ser_in), .serial_out(ser_out),
        .tx_line(tx_line), .tx_empty_in(1'b1), .tx_room_in(1'b1), .tx_empty_flag(txe),
        .tx_room_flag(txr), .tx_wr_block(wr_blk), .req_to_send_n(rts_n),
        .rx_ready_pin_n(rdy_n));
    // Baud divisor 1 gives 16 ticks of 2 clocks a bit
    urx_far_end #(.BIT_CLKS(32)) far (.aclk(aclk), .line(far_line));
    // In local loop the outside line carries hostile inverted traffic
    assign ser_in  = loc ? ~far_line : far_line;
    assign tx_line = loc ? far_line : 1'b1;

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    always @(posedge aclk) if (!ser_out) low_cnt <= low_cnt + 1;

    task automatic report_and_stop;
        if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        rsp = bresp;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        got = rdata;
        rsp = rresp;
    endtask : rd

    task automatic t_fill;
        wr(8'h00, 32'h4);
        wr(8'h04, 32'h1);
        for (int i = 0; i < 4; i++) far.send(8'h30 + 8'(i), 1'b0, 1'b0, 1'b0);
        rd(8'h08);
        chk(got & 32'hf3, 32'h03, "full status");
        rd(8'h08);
        chk(got & 32'hf3, 32'h03, "status reread");
        chk(rts_n, 1'b1, "flow negated");
        far.send(8'h34, 1'b0, 1'b0, 1'b0);
        rd(8'h08);
        chk(got & 32'h13, 32'h13, "overrun");
        for (int i = 0; i < 4; i++) begin
            rd(8'h08);
            if (i == 2) chk(rts_n, 1'b0, "flow reasserted");
            rd(8'h0c);
            chk(got, i < 3 ? 32'h30 + i : 32'h34, "fifo order");
        end
        rd(8'h08);
        chk(got & 32'h03, 32'h0, "drained");
        wr(8'h04, 32'h8);
        rd(8'h08);
        chk(got & 32'h10, 32'h0, "overrun cleared");
    endtask : t_fill

    task automatic t_errors;
        wr(8'h00, 32'h20);
        far.send(8'h5a, 1'b1, 1'b1, 1'b0);
        far.send(8'h55, 1'b1, 1'b0, 1'b1);
        far.send(8'h00, 1'b1, 1'b0, 1'b1);
        rd(8'h08);
        chk(got & 32'he0, 32'h20, "head parity");
        rd(8'h0c);
        chk(got, 32'h5a, "parity char");
        rd(8'h08);
        chk(got & 32'he0, 32'h40, "head framing");
        rd(8'h10);
        chk(got[1], 1'b1, "avail source");
        chk(rdy_n, 1'b0, "ready pin low");
        wr(8'h00, 32'h22);
        rd(8'h10);
        chk(got[1], 1'b0, "full source");
        chk(rdy_n, 1'b1, "ready pin high");
        rd(8'h0c);
        rd(8'h08);
        chk(got & 32'h80, 32'h80, "head break");
        rd(8'h0c);
        chk(got, 32'h0, "break char");
        wr(8'h00, 32'h21);
        wr(8'h04, 32'h8);
        far.send(8'h5a, 1'b1, 1'b1, 1'b0);
        far.send(8'h11, 1'b1, 1'b0, 1'b0);
        rd(8'h0c);
        rd(8'h0c);
        rd(8'h08);
        chk(got & 32'he0, 32'h20, "block sticky");
        wr(8'h04, 32'h8);
        rd(8'h08);
        chk(got & 32'he0, 32'h0, "block cleared");
    endtask : t_errors

    task automatic t_reset;
        wr(8'h00, 32'h0);
        far.send(8'h61, 1'b0, 1'b0, 1'b0);
        far.send(8'h62, 1'b0, 1'b0, 1'b0);
        wr(8'h04, 32'h2);
        rd(8'h0c);
        chk(got, 32'h61, "read disabled");
        wr(8'h04, 32'h4);
        rd(8'h08);
        chk(got & 32'hf3, 32'h0, "receiver reset");
        chk(rdy_n, 1'b1, "ready pin reset");
        far.send(8'h63, 1'b0, 1'b0, 1'b0);
        rd(8'h08);
        chk(got & 32'h01, 32'h0, "rx after reset");
        wr(8'h04, 32'h1);
    endtask : t_reset

    task automatic t_loops;
        int l0;
        wr(8'h00, 32'h08);
        chk(wr_blk, 1'b1, "echo blocks tx");
        chk(txe | txr, 1'b0, "echo tx flags");
        l0 = low_cnt;
        far.send(8'h0f, 1'b0, 1'b0, 1'b0);
        chk(low_cnt > l0, 1'b1, "echo on line");
        rd(8'h0c);
        chk(got, 32'h0f, "echo delivers");
        loc <= 1'b1;
        wr(8'h00, 32'h10);
        l0 = low_cnt;
        far.send(8'h3c, 1'b0, 1'b0, 1'b0);
        chk(low_cnt == l0, 1'b1, "local holds mark");
        rd(8'h0c);
        chk(got, 32'h3c, "local receive");
        loc <= 1'b0;
        wr(8'h00, 32'h38);
        l0 = low_cnt;
        far.send(8'hc3, 1'b1, 1'b1, 1'b0);
        chk(low_cnt > l0, 1'b1, "remote echo");
        chk(wr_blk, 1'b1, "remote blocks tx");
        rd(8'h08);
        chk(got & 32'he1, 32'h0, "remote hides data");
        wr(8'h00, 32'h0);
        chk(wr_blk, 1'b0, "normal routing");
    endtask : t_loops

    task automatic t_bus;
        rd(8'h18);
        chk(rsp, 2'h3, "unmapped rd resp");
        chk(got, 32'h0, "unmapped rd data");
        wr(8'h1c, 32'hff);
        chk(rsp, 2'h3, "unmapped wr resp");
    endtask : t_bus

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, loc} = '0;
        {awaddr, araddr, wdata} = '0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        wr(8'h14, 32'h1);
        t_fill;
        t_errors;
        t_reset;
        t_loops;
        t_bus;
        report_and_stop;
    end

    initial begin
        repeat (60000) @(posedge aclk);
        fail_count++;
        report_and_stop;
    end
endmodule : urx_core_tb

bind urx_core urx_core_props u_props (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .serial_out, .tx_empty_in, .tx_room_in,
    .tx_empty_flag, .tx_room_flag, .tx_wr_block, .req_to_send_n, .rx_ready_pin_n);

// ---- verification/urx_far_end.sv ----
// Remote serial transmitter that drives the receive line
`timescale 1ns/1ps
module urx_far_end #(
    parameter int BIT_CLKS = 32
) (
    input  wire logic aclk,
    output      logic line
);
    initial line = 1'b1;

    task automatic hold(input logic v, input int n);
        line <= v;
        repeat (n) @(posedge aclk);
    endtask : hold

    // Start, eight data bits LSB first, optional even parity, one stop
    task automatic send(input logic [7:0] d, input logic pe, input logic bp, input logic bs);
        @(posedge aclk);
        hold(1'b0, BIT_CLKS);
        for (int i = 0; i < 8; i++) hold(d[i], BIT_CLKS);
        if (pe) hold(^d ^ bp, BIT_CLKS);
        // A bad stop stays low only past the centre sample, so no false start
        if (bs) hold(1'b0, BIT_CLKS * 3 / 4);
        hold(1'b1, BIT_CLKS * 3);
    endtask : send
endmodule : urx_far_end
